/* File: logic/parity_status_pkg.sv */
/*
  Shared constants for the bridge parity status block: register offsets,
  field positions, reset values, transaction codes and bus-slave states.
  Assumes a 32-bit Avalon-MM register bus with byte addresses.
*/
package parity_status_pkg;

  // Register byte offsets on the Avalon-MM slave.
  localparam logic [3:0] ctrl_offset = 4'h0;
  localparam logic [3:0] status_offset = 4'h4;
  localparam logic [3:0] irq_status_offset = 4'h8;
  localparam logic [3:0] irq_mask_offset = 4'hc;

  // Control register fields: the two parity error response enables.
  localparam int ctrl_pri_resp_bit = 0;
  localparam int ctrl_sec_resp_bit = 1;
  localparam int ctrl_width = 2;
  localparam logic [1:0] ctrl_reset = 2'h0;

  // Status, interrupt status and mask share this layout.
  localparam int pri_det_bit = 0;
  localparam int sec_det_bit = 1;
  localparam int pri_dpd_bit = 2;
  localparam int sec_dpd_bit = 3;
  localparam int status_width = 4;
  localparam logic [3:0] status_reset = 4'h0;
  localparam logic [3:0] mask_reset = 4'h0;

  // Width of the bus read data and the value read from unmapped offsets.
  localparam int data_width = 32;
  localparam logic [31:0] unmapped_data = 32'h0000_0000;

  // Transaction type codes presented by the bridge core.
  typedef enum logic [1:0] {
    txn_read_type = 2'h0,
    txn_posted_type = 2'h1,
    txn_delayed_type = 2'h2,
    txn_none_type = 2'h3
  } txn_type;

  // Direction code: downstream runs primary to secondary.
  localparam logic dir_downstream = 1'b0;
  localparam logic dir_upstream = 1'b1;

  // Bus slave states, one-hot.
  typedef enum logic [1:0] {
    idle_st = 2'b01,
    answer_st = 2'b10
  } slave_state_type;

endpackage

/* File: logic/bridge_parity_status_logic.sv */
/*
  Parity status decision logic of a two-sided PCI-to-PCI bridge. It sets the
  primary and secondary detected-parity-error bits and the primary and
  secondary data-parity-detected bits from parity events, and offers them over
  an Avalon-MM slave with an interrupt built on the same four events.
  Assumes the bridge core drives the mismatch pulses, the transaction
  type/direction and the master-role levels on this clock, and that the two
  parity error pins come asynchronously from the PCI buses.
*/
// Functional notes
// RULE_01: Primary detected bit ignores both response enables.
// RULE_02: Secondary detected bit ignores both response enables.
// RULE_03: Primary detected: upstream read, downstream writes only.
// RULE_04: Secondary detected: downstream read, upstream writes only.
// RULE_05: Primary data-parity bit needs primary master role.
// RULE_06: Primary data-parity bit needs primary response enable.
// RULE_07: Primary data-parity: sampled error pin or mismatch.
// RULE_08: Primary data-parity only for upstream primary errors.
// RULE_09: Secondary data-parity bit needs secondary master role.
// RULE_10: Secondary data-parity bit needs secondary response enable.
// RULE_11: Secondary data-parity: sampled error pin or mismatch.
// RULE_12: Secondary target error downstream sets secondary data-parity.
// RULE_13: Status bits stay until software writes one.
module bridge_parity_status_logic (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic primary_parity_err_n,
  input wire logic secondary_parity_err_n,
  input wire logic pri_parity_mismatch,
  input wire logic sec_parity_mismatch,
  input wire logic [1:0] txn_kind,
  input wire logic txn_dir,
  input wire logic pri_master_active,
  input wire logic sec_master_active,
  output logic [3:0] parity_status,
  output logic irq
);

  // Decides whether a case belongs to the primary detected bit.
  function automatic logic pri_det_case(input logic [1:0] kind, input logic dir);
    pri_det_case = (kind == parity_status_pkg::txn_read_type &&
                    dir == parity_status_pkg::dir_upstream) ||
                   ((kind == parity_status_pkg::txn_posted_type ||
                     kind == parity_status_pkg::txn_delayed_type) &&
                    dir == parity_status_pkg::dir_downstream);
  endfunction

  // Mirror image of the primary case for the secondary detected bit.
  function automatic logic sec_det_case(input logic [1:0] kind, input logic dir);
    sec_det_case = (kind == parity_status_pkg::txn_read_type &&
                    dir == parity_status_pkg::dir_downstream) ||
                   ((kind == parity_status_pkg::txn_posted_type ||
                     kind == parity_status_pkg::txn_delayed_type) &&
                    dir == parity_status_pkg::dir_upstream);
  endfunction

  logic pri_perr_meta_ff;
  logic pri_perr_sync_ff;
  logic sec_perr_meta_ff;
  logic sec_perr_sync_ff;
  logic [1:0] ctrl_ff;
  logic [3:0] status_ff;
  logic [3:0] irq_status_ff;
  logic [3:0] irq_mask_ff;
  logic [31:0] readdata_ff;
  logic waitrequest_ff;
  logic irq_ff;
  parity_status_pkg::slave_state_type state_ff;
  parity_status_pkg::slave_state_type nxt_state;
  logic [31:0] nxt_readdata;
  logic [3:0] event_vec;
  logic [3:0] status_clear;
  logic [3:0] nxt_status;
  logic [3:0] nxt_irq_status;
  logic [3:0] irq_read_clear;
  logic [3:0] status_kept;
  logic accept_wr;
  logic accept_rd;
  logic pri_resp;
  logic sec_resp;
  logic pri_known_kind;
  logic sec_known_kind;

  // Two flops on each parity error pin; the PCI buses run on their own clocks.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pri_perr_meta_ff <= 1'b1;
      pri_perr_sync_ff <= 1'b1;
      sec_perr_meta_ff <= 1'b1;
      sec_perr_sync_ff <= 1'b1;
    end else begin
      pri_perr_meta_ff <= primary_parity_err_n;
      pri_perr_sync_ff <= pri_perr_meta_ff;
      sec_perr_meta_ff <= secondary_parity_err_n;
      sec_perr_sync_ff <= sec_perr_meta_ff;
    end
  end

  // Response enables as software programmed them.
  assign pri_resp = ctrl_ff[parity_status_pkg::ctrl_pri_resp_bit];
  assign sec_resp = ctrl_ff[parity_status_pkg::ctrl_sec_resp_bit];
  assign pri_known_kind = txn_kind != parity_status_pkg::txn_none_type;
  assign sec_known_kind = txn_kind != parity_status_pkg::txn_none_type;

  // Detected bits depend only on where the error showed and on the case,
  // never on the response enables. [RULE_01] [RULE_02]
  assign event_vec[parity_status_pkg::pri_det_bit] =
    pri_parity_mismatch && pri_det_case(txn_kind, txn_dir); // [RULE_03]
  assign event_vec[parity_status_pkg::sec_det_bit] =
    sec_parity_mismatch && sec_det_case(txn_kind, txn_dir); // [RULE_04]

  // Data-parity-detected bits: master role, enable, and either a sampled
  // error pin or our own mismatch. A downstream-only write case cannot set
  // the primary bit because its term also requires txn_dir upstream, whatever the master role.
  assign event_vec[parity_status_pkg::pri_dpd_bit] =
    pri_master_active && // [RULE_05]
    pri_resp && // [RULE_06]
    (!pri_perr_sync_ff || pri_parity_mismatch) && // [RULE_07]
    pri_known_kind && txn_dir == parity_status_pkg::dir_upstream; // [RULE_08]
  assign event_vec[parity_status_pkg::sec_dpd_bit] =
    sec_master_active && // [RULE_09]
    sec_resp && // [RULE_10]
    (!sec_perr_sync_ff || sec_parity_mismatch) && // [RULE_11]
    sec_known_kind && txn_dir == parity_status_pkg::dir_downstream; // [RULE_12]

  // A request is acted on only at the edge where waitrequest is seen low.
  assign accept_wr = avs_write && !waitrequest_ff;
  assign accept_rd = avs_read && !waitrequest_ff;

  // Write-one-to-clear mask for the status register, lane 0 only.
  assign status_clear = (accept_wr && avs_byteenable[0] &&
                         avs_address == parity_status_pkg::status_offset) ?
                        avs_writedata[3:0] : parity_status_pkg::status_reset;
  assign status_kept = status_ff & ~status_clear;

  // A new event wins over a clear in the same cycle.
  assign nxt_status = status_kept | event_vec; // [RULE_13]
  // A read clears only the bits that it returned, so an event landing after
  // the capture edge is not lost.
  assign irq_read_clear = (accept_rd &&
                           avs_address == parity_status_pkg::irq_status_offset) ?
                          readdata_ff[3:0] : parity_status_pkg::status_reset;
  assign nxt_irq_status = (irq_status_ff & ~irq_read_clear) | event_vec;

  // Sticky parity status bits.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      status_ff <= parity_status_pkg::status_reset;
    end else begin
      status_ff <= nxt_status; // [RULE_13]
    end
  end

  // Interrupt status clears on read; the event still wins.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      irq_status_ff <= parity_status_pkg::status_reset;
    end else begin
      irq_status_ff <= nxt_irq_status;
    end
  end

  // Interrupt level follows the masked status one cycle later.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(irq_status_ff & irq_mask_ff);
    end
  end

  // Software-written control and mask registers.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ctrl_ff <= parity_status_pkg::ctrl_reset;
      irq_mask_ff <= parity_status_pkg::mask_reset;
    end else if (accept_wr && avs_byteenable[0]) begin
      if (avs_address == parity_status_pkg::ctrl_offset) begin
        ctrl_ff <= avs_writedata[1:0];
      end
      if (avs_address == parity_status_pkg::irq_mask_offset) begin
        irq_mask_ff <= avs_writedata[3:0];
      end
    end
  end

  // Read multiplexer; unmapped offsets answer zero.
  always_comb begin
    nxt_readdata = parity_status_pkg::unmapped_data;
    case (avs_address)
      parity_status_pkg::ctrl_offset: begin
        nxt_readdata[1:0] = ctrl_ff;
      end
      parity_status_pkg::status_offset: begin
        nxt_readdata[3:0] = status_ff;
      end
      parity_status_pkg::irq_status_offset: begin
        nxt_readdata[3:0] = irq_status_ff;
      end
      parity_status_pkg::irq_mask_offset: begin
        nxt_readdata[3:0] = irq_mask_ff;
      end
      default: begin
        nxt_readdata = parity_status_pkg::unmapped_data;
      end
    endcase
  end

  // One wait cycle per access, so read data can come from a flop and the
  // decode never sits in a long combinational path to the master.
  always_comb begin
    case (state_ff)
      parity_status_pkg::idle_st: begin
        nxt_state = (avs_read || avs_write) ? parity_status_pkg::answer_st :
                    parity_status_pkg::idle_st;
      end
      parity_status_pkg::answer_st: begin
        nxt_state = parity_status_pkg::idle_st;
      end
      default: begin
        nxt_state = parity_status_pkg::idle_st;
      end
    endcase
  end

  // Slave state and waitrequest.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_ff <= parity_status_pkg::idle_st;
      waitrequest_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      waitrequest_ff <= nxt_state != parity_status_pkg::answer_st;
    end
  end

  // Read data is captured as the answer cycle opens.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      readdata_ff <= parity_status_pkg::unmapped_data;
    end else if (state_ff == parity_status_pkg::idle_st && avs_read) begin
      readdata_ff <= nxt_readdata;
    end
  end

  assign avs_readdata = readdata_ff;
  assign avs_waitrequest = waitrequest_ff;
  assign parity_status = status_ff;
  assign irq = irq_ff;

  // Primary mismatch in an upstream read, whatever the response enables.
  sequence s_pri_det_cause;
    pri_parity_mismatch && txn_kind == parity_status_pkg::txn_read_type &&
      txn_dir == parity_status_pkg::dir_upstream;
  endsequence

  property p_pri_det_any_enable;
    @(posedge clock) disable iff (!rstn)
      s_pri_det_cause |=> status_ff[parity_status_pkg::pri_det_bit];
  endproperty
  a_pri_det_any_enable: assert property (p_pri_det_any_enable) // [RULE_01]
    else $error("Primary detected bit not set on primary read error.");

  property p_sec_det_any_enable;
    @(posedge clock) disable iff (!rstn)
      (sec_parity_mismatch && txn_dir == parity_status_pkg::dir_upstream &&
       txn_kind == parity_status_pkg::txn_posted_type)
      |=> status_ff[parity_status_pkg::sec_det_bit];
  endproperty
  a_sec_det_any_enable: assert property (p_sec_det_any_enable) // [RULE_02]
    else $error("Secondary detected bit not set on upstream posted error.");

  property p_pri_det_only_cases;
    @(posedge clock) disable iff (!rstn)
      (!status_ff[parity_status_pkg::pri_det_bit] &&
       !(pri_parity_mismatch && pri_det_case(txn_kind, txn_dir)))
      |=> !status_ff[parity_status_pkg::pri_det_bit];
  endproperty
  a_pri_det_only_cases: assert property (p_pri_det_only_cases) // [RULE_03]
    else $error("Primary detected bit set outside its cases.");

  property p_sec_det_only_cases;
    @(posedge clock) disable iff (!rstn)
      (!status_ff[parity_status_pkg::sec_det_bit] &&
       !(sec_parity_mismatch && sec_det_case(txn_kind, txn_dir)))
      |=> !status_ff[parity_status_pkg::sec_det_bit];
  endproperty
  a_sec_det_only_cases: assert property (p_sec_det_only_cases) // [RULE_04]
    else $error("Secondary detected bit set outside its cases.");

  property p_pri_dpd_needs_master;
    @(posedge clock) disable iff (!rstn)
      (!status_ff[parity_status_pkg::pri_dpd_bit] &&
       !(pri_master_active && pri_resp))
      |=> !status_ff[parity_status_pkg::pri_dpd_bit];
  endproperty
  a_pri_dpd_needs_master: assert property (p_pri_dpd_needs_master) // [RULE_05]
    else $error("Primary data parity bit set without master role or enable.");

  // Error pin held low for three cycles while the bridge masters upstream.
  sequence s_pri_pin_held;
    (!primary_parity_err_n && pri_master_active && pri_resp && pri_known_kind &&
     txn_dir == parity_status_pkg::dir_upstream)[*3];
  endsequence

  property p_pri_dpd_from_pin;
    @(posedge clock) disable iff (!rstn)
      s_pri_pin_held |=> status_ff[parity_status_pkg::pri_dpd_bit];
  endproperty
  a_pri_dpd_from_pin: assert property (p_pri_dpd_from_pin) // [RULE_07]
    else $error("Primary data parity bit missed a sampled target error.");

  property p_pri_dpd_not_downstream;
    @(posedge clock) disable iff (!rstn)
      (!status_ff[parity_status_pkg::pri_dpd_bit] &&
       txn_dir == parity_status_pkg::dir_downstream)
      |=> !status_ff[parity_status_pkg::pri_dpd_bit];
  endproperty
  a_pri_dpd_not_downstream: assert property (p_pri_dpd_not_downstream) // [RULE_08]
    else $error("Primary data parity bit set on a downstream case.");

  property p_sec_dpd_needs_enable;
    @(posedge clock) disable iff (!rstn)
      (!status_ff[parity_status_pkg::sec_dpd_bit] &&
       !(sec_master_active && sec_resp))
      |=> !status_ff[parity_status_pkg::sec_dpd_bit];
  endproperty
  a_sec_dpd_needs_enable: assert property (p_sec_dpd_needs_enable) // [RULE_10]
    else $error("Secondary data parity bit set without master role or enable.");

  // Secondary target pulls its error pin during a downstream transfer.
  sequence s_sec_pin_held;
    (!secondary_parity_err_n && sec_master_active && sec_resp && sec_known_kind &&
     txn_dir == parity_status_pkg::dir_downstream)[*3];
  endsequence

  property p_sec_dpd_from_pin;
    @(posedge clock) disable iff (!rstn)
      s_sec_pin_held |=> status_ff[parity_status_pkg::sec_dpd_bit];
  endproperty
  a_sec_dpd_from_pin: assert property (p_sec_dpd_from_pin) // [RULE_12]
    else $error("Secondary data parity bit missed a target error.");

  property p_sec_dpd_from_mismatch;
    @(posedge clock) disable iff (!rstn)
      (sec_parity_mismatch && sec_master_active && sec_resp && sec_known_kind &&
       txn_dir == parity_status_pkg::dir_downstream)
      |=> status_ff[parity_status_pkg::sec_dpd_bit];
  endproperty
  a_sec_dpd_from_mismatch: assert property (p_sec_dpd_from_mismatch) // [RULE_11]
    else $error("Secondary data parity bit missed an own mismatch.");

  property p_status_sticky;
    @(posedge clock) disable iff (!rstn)
      1'b1 |=> ((status_ff & $past(status_kept)) == $past(status_kept));
  endproperty
  a_status_sticky: assert property (p_status_sticky) // [RULE_13]
    else $error("A status bit dropped without a write of one.");

endmodule

/* File: verification/pci_agent_model.sv */
/*
  Model of the PCI agents on the primary and secondary buses as seen by the
  parity status block: a target that drives the active-low parity error pin.
  Assumes the testbench calls report_error just after a rising clock edge.
*/
module pci_agent_model (
  input wire logic clock,
  output logic primary_parity_err_n,
  output logic secondary_parity_err_n
);
  timeunit 1ns;
  timeprecision 1ns;

  // Both pins start high and report_error drives them high on release, so a released pin never reads a stale low.
  initial begin
    primary_parity_err_n = 1'b1;
    secondary_parity_err_n = 1'b1;
  end

  // A target holds the pin low for whole clock cycles, then releases it.
  task automatic report_error(input logic on_secondary, input int cycles);
    if (on_secondary) secondary_parity_err_n <= 1'b0;
    else primary_parity_err_n <= 1'b0;
    repeat (cycles) @(posedge clock);
    primary_parity_err_n <= 1'b1;
    secondary_parity_err_n <= 1'b1;
  endtask
endmodule

/* File: verification/testbench.sv */
/*
  Self-checking testbench for the bridge parity status block.
  Assumes the register bus answers with one wait cycle, mismatch pulses land
  one edge later and pin events three edges after the pin falls.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ns;

  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  wire primary_parity_err_n;
  wire secondary_parity_err_n;
  logic pri_parity_mismatch = 1'b0;
  logic sec_parity_mismatch = 1'b0;
  logic [1:0] txn_kind = 2'h3;
  logic txn_dir = 1'b0;
  logic pri_master_active = 1'b0;
  logic sec_master_active = 1'b0;
  logic [3:0] parity_status;
  logic irq;
  int err_count = 0;
  int n_checks = 0;
  logic [31:0] rd;

  // Free-running 10 MHz clock.
  always #50 clock = ~clock;

  bridge_parity_status_logic bridge_parity_status_logic_inst (
    .clock(clock), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .primary_parity_err_n(primary_parity_err_n),
    .secondary_parity_err_n(secondary_parity_err_n),
    .pri_parity_mismatch(pri_parity_mismatch), .sec_parity_mismatch(sec_parity_mismatch),
    .txn_kind(txn_kind), .txn_dir(txn_dir), .pri_master_active(pri_master_active),
    .sec_master_active(sec_master_active), .parity_status(parity_status), .irq(irq)
  );

  pci_agent_model pci_agent_model_inst (
    .clock(clock), .primary_parity_err_n(primary_parity_err_n),
    .secondary_parity_err_n(secondary_parity_err_n)
  );

  // Verdict and end of run, shared by the main sequence and the watchdog.
  task automatic final_report;
    $display("Checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Comparisons use case equality so an unknown never passes.
  task automatic check_bits(input logic [3:0] got, input logic [3:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t bits %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t word %h expected %h", $time, got, exp);
    end
  endtask

  // One Avalon-MM access; the request holds until waitrequest is sampled low.
  task automatic bus_access(input logic wr, input logic [3:0] a, input logic [31:0] d,
                            input logic [3:0] be, output logic [31:0] q);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    if (wr) avs_write <= 1'b1;
    else avs_read <= 1'b1;
    @(posedge clock);
    while (avs_waitrequest !== 1'b0 && n < 50) begin
      @(posedge clock);
      n++;
    end
    if (n >= 50) begin
      err_count++;
      $display("ERROR %0t bus answer missing", $time);
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    // An idle edge keeps the next request from reassigning strobes in this step.
    @(posedge clock);
  endtask

  task automatic clear_all;
    bus_access(1'b1, 4'h4, 32'hf, 4'hf, rd);
    bus_access(1'b0, 4'h8, 32'h0, 4'hf, rd);
  endtask

  task automatic t_reset_values;
    check_bits(parity_status, 4'h0);
    check_bits({3'h0, irq}, 4'h0);
    for (int a = 0; a < 16; a += 4) begin
      bus_access(1'b0, a[3:0], 32'h0, 4'hf, rd);
      check_word(rd, 32'h0);
    end
    bus_access(1'b1, 4'h2, 32'hf, 4'hf, rd);
    bus_access(1'b0, 4'h2, 32'h0, 4'hf, rd);
    check_word(rd, 32'h0);
  endtask

  // Every type, direction and bus from a mismatch, with both enables and both master roles switched on or off together.
  task automatic t_table;
    logic [3:0] exp;
    logic wr_kind;
    for (int m = 0; m < 4; m++) begin
      bus_access(1'b1, 4'h0, {30'h0, m[0], m[0]}, 4'hf, rd);
      pri_master_active <= m[1];
      sec_master_active <= m[1];
      for (int k = 0; k < 4; k++) begin
        for (int s = 0; s < 4; s++) begin
          clear_all;
          txn_kind <= k[1:0];
          txn_dir <= s[0];
          pri_parity_mismatch <= ~s[1];
          sec_parity_mismatch <= s[1];
          @(posedge clock);
          pri_parity_mismatch <= 1'b0;
          sec_parity_mismatch <= 1'b0;
          @(posedge clock);
          wr_kind = (k == 1 || k == 2);
          exp[0] = !s[1] && ((k == 0 && s[0]) || (wr_kind && !s[0]));
          exp[1] = s[1] && ((k == 0 && !s[0]) || (wr_kind && s[0]));
          exp[2] = !s[1] && s[0] && k != 3 && m[1] && m[0];
          exp[3] = s[1] && !s[0] && k != 3 && m[1] && m[0];
          check_bits(parity_status, exp);
          check_bits(parity_status & 4'hc, exp & 4'hc);
        end
      end
    end
    txn_kind <= 2'h3;
  endtask

  // Bits stay set until a one is written at their position.
  task automatic t_sticky;
    clear_all;
    bus_access(1'b1, 4'h0, 32'h3, 4'hf, rd);
    pri_master_active <= 1'b1;
    txn_kind <= 2'h1;
    txn_dir <= 1'b1;
    pri_parity_mismatch <= 1'b1;
    sec_parity_mismatch <= 1'b1;
    @(posedge clock);
    pri_parity_mismatch <= 1'b0;
    sec_parity_mismatch <= 1'b0;
    txn_kind <= 2'h3;
    repeat (20) @(posedge clock);
    check_bits(parity_status, 4'h6);
    bus_access(1'b1, 4'h4, 32'h0, 4'hf, rd);
    bus_access(1'b1, 4'h4, 32'hf, 4'he, rd);
    check_bits(parity_status, 4'h6);
    bus_access(1'b0, 4'h4, 32'h0, 4'hf, rd);
    check_word(rd, 32'h6);
    bus_access(1'b1, 4'h4, 32'h2, 4'hf, rd);
    check_bits(parity_status, 4'h4);
    bus_access(1'b1, 4'h4, 32'h4, 4'hf, rd);
    check_bits(parity_status, 4'h0);
  endtask

  // Interrupt status from the sticky scenario is still pending but masked.
  task automatic t_irq;
    check_bits({3'h0, irq}, 4'h0);
    bus_access(1'b1, 4'hc, 32'h4, 4'hf, rd);
    // The interrupt level follows the masked status one edge later.
    @(posedge clock);
    check_bits({3'h0, irq}, 4'h1);
    bus_access(1'b0, 4'hc, 32'h0, 4'hf, rd);
    check_word(rd, 32'h4);
    bus_access(1'b0, 4'h8, 32'h0, 4'hf, rd);
    check_word(rd, 32'h6);
    @(posedge clock);
    check_bits({3'h0, irq}, 4'h0);
    bus_access(1'b1, 4'hc, 32'h0, 4'hf, rd);
  endtask

  // A target pulls a parity error pin low, with the bridge mastering that bus only when mst is set.
  task automatic t_pin(input logic on_sec, input logic en, input logic mst,
                       input logic [3:0] exp);
    bus_access(1'b1, 4'h0, {30'h0, en, en}, 4'hf, rd);
    clear_all;
    pri_master_active <= mst & ~on_sec;
    sec_master_active <= mst & on_sec;
    txn_kind <= 2'h1;
    txn_dir <= ~on_sec;
    @(posedge clock);
    // Three low cycles, so the pin-held assertions see their whole antecedent.
    pci_agent_model_inst.report_error(on_sec, 3);
    repeat (5) @(posedge clock);
    check_bits(parity_status & 4'hc, exp);
    txn_kind <= 2'h3;
  endtask

  initial begin
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    t_reset_values;
    t_table;
    t_sticky;
    t_irq;
    t_pin(1'b0, 1'b1, 1'b1, 4'h4);
    t_pin(1'b0, 1'b0, 1'b1, 4'h0);
    t_pin(1'b0, 1'b1, 1'b0, 4'h0);
    t_pin(1'b1, 1'b1, 1'b1, 4'h8);
    t_pin(1'b1, 1'b0, 1'b1, 4'h0);
    t_pin(1'b1, 1'b1, 1'b0, 4'h0);
    final_report;
  end

  // The tests need well under 20000 cycles; a hang ends the run here.
  initial begin
    #2000000;
    err_count++;
    $display("ERROR %0t watchdog expired", $time);
    final_report;
  end
endmodule
